// ### bench/axi_host_model.sv
// Host bus master model driving the register port
`timescale 1ns/1ps
module axi_host_model
    import buck_setpoint_pkg::*;
(
    input wire logic ref_clk_i,
    output logic [ADDR_W-1:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [ADDR_W-1:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    // Idle bus at time zero
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end

    // Write: both items offered, each dropped once taken, payload scrambled
    task automatic wr(input logic [6:0] idx, input logic [31:0] d, output logic [1:0] r);
        logic a_done;
        logic w_done;
        a_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk_i);
        awaddr_o <= {idx, 2'b00};
        wdata_o <= d;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        while (!(a_done && w_done)) begin
            @(posedge ref_clk_i);
            if (!a_done && awready_i) begin
                a_done = 1'b1;
                awvalid_o <= 1'b0;
                awaddr_o <= ~awaddr_o;
            end
            if (!w_done && wready_i) begin
                w_done = 1'b1;
                wvalid_o <= 1'b0;
                wdata_o <= ~wdata_o;
            end
        end
        do @(posedge ref_clk_i); while (!bvalid_i);
        r = bresp_i;
        bready_o <= 1'b0;
    endtask

    // Read: address held until taken, data taken with rready high
    task automatic rd(input logic [6:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk_i);
        araddr_o <= {idx, 2'b00};
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do @(posedge ref_clk_i); while (!arready_i);
        arvalid_o <= 1'b0;
        araddr_o <= ~araddr_o;
        do @(posedge ref_clk_i); while (!rvalid_i);
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask
endmodule

// ### bench/tb.sv
// Self-checking bench of the buck set-point control block
`timescale 1ns/1ps
module tb;
    import buck_setpoint_pkg::*;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic fuse_load = 1'b0;
    logic fuse_trk = 1'b0;
    logic fuse_rng = 1'b0;
    logic [1:0] op = 2'h0;
    logic [11:0] paired = 12'h000;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, trk_o;
    logic [31:0] wdata, rdata, rd, seed, held;
    logic [1:0] bresp, rresp, rs;
    logic [11:0] ref_mv;
    logic [3:0] sw_mode;
    int n_mismatch = 0;
    int n_checks = 0;
    int code[3];
    int rng, trk, mode;

    always #20 ref_clk_i = ~ref_clk_i;

    buck_setpoint_control u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .fuse_load_i(fuse_load),
        .fuse_tracking_i(fuse_trk), .fuse_range_i(fuse_rng), .op_state_i(op),
        .paired_buck_a_mv_i(paired), .ref_mv_o(ref_mv), .sw_mode_o(sw_mode),
        .termination_tracking_mode_o(trk_o));

    axi_host_model u_host (.ref_clk_i(ref_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready),
        .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
        .rvalid_i(rvalid), .rready_o(rready));

    // ------------------------------------------------------------------
    // Helpers and reference model
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function int exp_ref();
        int n;
        n = code[(op == OP_STANDBY) ? 1 : (op == OP_SLEEP) ? 2 : 0];
        if (trk != 0) return paired / 2;
        return (rng != 0) ? 800 + 50 * n : 400 + 25 * n;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [6:0] idx, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        u_host.rd(idx, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic fuse(input logic t, input logic r);
        @(posedge ref_clk_i);
        fuse_load <= 1'b1;
        fuse_trk <= t;
        fuse_rng <= r;
        @(posedge ref_clk_i);
        fuse_load <= 1'b0;
        fuse_trk <= ~t;
        fuse_rng <= ~r;
        trk = t;
        rng = r;
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk_i);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'h6DC5;
        trk = 0;
        rng = 0;
        mode = 8;
        code = '{0, 0, 0};
        repeat (4) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        rchk(IDX_NORMAL, 32'h0);
        rchk(IDX_SLEEP, 32'h0);
        rchk(IDX_MODE, 32'h8);
        u_host.wr(7'h10, 32'hFF, rs);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        u_host.rd(7'h10, rd, rs);
        chk(rd, 32'h0);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        for (int p = 0; p < 4; p++) begin
            fuse(1'b0, p[0]);
            for (int i = 0; i < 3; i++) begin
                seed = lfsr(seed);
                code[i] = (rng != 0) ? 24 + seed % 27 : 9 + seed % 55;
                u_host.wr(7'(IDX_NORMAL + i), 32'hC0 | code[i], rs);
                rchk(7'(IDX_NORMAL + i), (rng << 6) | code[i]);
            end
            seed = lfsr(seed);
            mode = seed % 16;
            u_host.wr(IDX_MODE, mode, rs);
            chk({30'h0, rs}, {30'h0, RESP_OKAY});
            rchk(IDX_MODE, mode);
            for (int s = 0; s < 4; s++) begin
                op <= 2'(s);
                settle();
                chk(ref_mv, exp_ref());
                chk(sw_mode, mode);
                chk(trk_o, 1'b0);
            end
        end
        fuse(1'b1, 1'b1);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            paired <= seed[11:0];
            op <= seed[13:12];
            settle();
            chk(ref_mv, exp_ref());
            chk(sw_mode, PWM_MODE_VAL);
            chk(trk_o, 1'b1);
        end
        u_host.wr(IDX_STATUS, 32'h0, rs);
        chk({30'h0, rs}, {30'h0, RESP_OKAY});
        rchk(IDX_STATUS, (exp_ref() << 4) | (op << 2) | (rng << 1) | trk);
        held = ref_mv;
        ce_i <= 1'b0;
        paired <= ~paired;
        settle();
        chk(ref_mv, held);
        ce_i <= 1'b1;
        settle();
        chk(ref_mv, exp_ref());
        wrap_up();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        wrap_up();
    end
endmodule

// ### common/buck_setpoint_pkg.sv
// Constants and types shared by the buck set-point control block
package buck_setpoint_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int IDX_W = 7;

    // ------------------------------------------------------------------
    // Register word indexes (byte address = 4 x index)
    // ------------------------------------------------------------------
    localparam logic [6:0] IDX_NORMAL = 7'h4A;
    localparam logic [6:0] IDX_STANDBY = 7'h4B;
    localparam logic [6:0] IDX_SLEEP = 7'h4C;
    localparam logic [6:0] IDX_MODE = 7'h4D;
    localparam logic [6:0] IDX_STATUS = 7'h50;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CODE_W = 6;
    localparam int RANGE_BIT = 6;
    localparam int MODE_W = 4;
    localparam int MV_W = 12;
    localparam int STAT_TRACK_BIT = 0;
    localparam int STAT_RANGE_BIT = 1;
    localparam int STAT_OP_LSB = 2;
    localparam int STAT_MV_LSB = 4;
    localparam logic DEFAULT_RANGE_VAL = 1'b0;
    localparam logic DEFAULT_TRACK_VAL = 1'b0;
    localparam logic [3:0] MODE_RESET_VAL = 4'h8;
    localparam logic [3:0] PWM_MODE_VAL = 4'h1;

    // ------------------------------------------------------------------
    // Output coding, millivolts
    // ------------------------------------------------------------------
    localparam logic [11:0] LOW_BASE_MV = 12'h190;
    localparam logic [11:0] LOW_STEP_MV = 12'h019;
    localparam logic [11:0] HIGH_BASE_MV = 12'h320;
    localparam logic [11:0] HIGH_STEP_MV = 12'h032;

    // ------------------------------------------------------------------
    // Bus responses and operating states
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] OP_NORMAL = 2'h0;
    localparam logic [1:0] OP_STANDBY = 2'h1;
    localparam logic [1:0] OP_SLEEP = 2'h2;

    typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
    typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_RESP = 1'b1} rd_state_t;

endpackage

// ### core/buck_setpoint_control.sv
// Set-point, range and tracking-mode control of the fourth buck
`timescale 1ns/1ps
module buck_setpoint_control
    import buck_setpoint_pkg::*;
#(
    parameter logic DEFAULT_RANGE = DEFAULT_RANGE_VAL,
    parameter logic DEFAULT_TRACKING = DEFAULT_TRACK_VAL,
    parameter logic [3:0] MODE_RESET = MODE_RESET_VAL,
    parameter logic [3:0] PWM_MODE = PWM_MODE_VAL
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic fuse_load_i,
    input wire logic fuse_tracking_i,
    input wire logic fuse_range_i,
    input wire logic [1:0] op_state_i,
    input wire logic [11:0] paired_buck_a_mv_i,
    output logic [11:0] ref_mv_o,
    output logic [3:0] sw_mode_o,
    output logic termination_tracking_mode_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0] norm_code;
        logic [5:0] stby_code;
        logic [5:0] sleep_code;
        logic [3:0] mode;
        logic range;
        logic tracking;
        wr_state_t wst;
        logic aw_held;
        logic w_held;
        logic [IDX_W-1:0] waddr;
        logic [7:0] wdata;
        logic wlane;
        logic [1:0] bresp;
        rd_state_t rst;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [11:0] ref_mv;
        logic [3:0] sw_mode;
    } state_t;

    localparam state_t RESET_ST = '{range: DEFAULT_RANGE, tracking: DEFAULT_TRACKING,
        mode: MODE_RESET, wst: WR_IDLE, rst: RD_IDLE, default: '0};

    state_t st_r;
    state_t st_nxt;
    logic [5:0] sel_code;
    logic [11:0] dec_mv;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic [IDX_W-1:0] ar_idx;

    // ------------------------------------------------------------------
    // Handshakes and outputs
    // ------------------------------------------------------------------
    assign s_axi_awready_o = ce_i && st_r.wst == WR_IDLE && !st_r.aw_held;
    assign s_axi_wready_o = ce_i && st_r.wst == WR_IDLE && !st_r.w_held;
    assign s_axi_arready_o = ce_i && st_r.rst == RD_IDLE;
    assign s_axi_bvalid_o = st_r.wst == WR_RESP;
    assign s_axi_rvalid_o = st_r.rst == RD_RESP;
    assign s_axi_bresp_o = st_r.bresp;
    assign s_axi_rresp_o = st_r.rresp;
    assign s_axi_rdata_o = st_r.rdata;
    assign ref_mv_o = st_r.ref_mv;
    assign sw_mode_o = st_r.sw_mode;
    assign termination_tracking_mode_o = st_r.tracking;
    assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
    assign w_take = s_axi_wvalid_i && s_axi_wready_o;
    assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
    assign ar_idx = s_axi_araddr_i[ADDR_W-1:2];

    // Set point for current operating state
    always_comb begin
        case (op_state_i)
            OP_STANDBY: sel_code = st_r.stby_code;
            OP_SLEEP: sel_code = st_r.sleep_code;
            default: sel_code = st_r.norm_code;
        endcase
    end

    setpoint_decode u_decode (
        .code_i(sel_code),
        .range_i(st_r.range),
        .mv_o(dec_mv)
    );

    // Register read mux, range bit mirrored in all three
    function automatic logic [31:0] read_word(input logic [IDX_W-1:0] idx,
                                              input state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx)
            IDX_NORMAL: w[7:0] = {1'b0, s.range, s.norm_code};
            IDX_STANDBY: w[7:0] = {1'b0, s.range, s.stby_code};
            IDX_SLEEP: w[7:0] = {1'b0, s.range, s.sleep_code};
            IDX_MODE: w[3:0] = s.mode;
            IDX_STATUS: begin
                w[STAT_TRACK_BIT] = s.tracking;
                w[STAT_RANGE_BIT] = s.range;
                w[STAT_OP_LSB +: 2] = op_state_i;
                w[STAT_MV_LSB +: MV_W] = s.ref_mv;
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    function automatic logic mapped(input logic [IDX_W-1:0] idx);
        return idx == IDX_NORMAL || idx == IDX_STANDBY || idx == IDX_SLEEP
            || idx == IDX_MODE || idx == IDX_STATUS;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Write address and data, either order
        if (aw_take) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.waddr = s_axi_awaddr_i[ADDR_W-1:2];
        end
        if (w_take) begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = s_axi_wdata_i[7:0];
            st_nxt.wlane = s_axi_wstrb_i[0];
        end
        case (st_r.wst)
            WR_IDLE: begin
                if (st_r.aw_held && st_r.w_held) begin
                    st_nxt.aw_held = 1'b0;
                    st_nxt.w_held = 1'b0;
                    st_nxt.wst = WR_RESP;
                    st_nxt.bresp = mapped(st_r.waddr) ? RESP_OKAY : RESP_SLVERR;
                    // Only set-point codes and mode are writable
                    if (st_r.wlane) begin
                        case (st_r.waddr)
                            IDX_NORMAL: st_nxt.norm_code = st_r.wdata[5:0];
                            IDX_STANDBY: st_nxt.stby_code = st_r.wdata[5:0];
                            IDX_SLEEP: st_nxt.sleep_code = st_r.wdata[5:0];
                            IDX_MODE: st_nxt.mode = st_r.wdata[3:0];
                            default: st_nxt.mode = st_r.mode;
                        endcase
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready_i) begin
                    st_nxt.wst = WR_IDLE;
                end
            end
            default: st_nxt.wst = WR_IDLE;
        endcase
        // Read channel
        case (st_r.rst)
            RD_IDLE: begin
                if (ar_take) begin
                    st_nxt.rst = RD_RESP;
                    st_nxt.rdata = read_word(ar_idx, st_r);
                    st_nxt.rresp = mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
                end
            end
            RD_RESP: begin
                if (s_axi_rready_i) begin
                    st_nxt.rst = RD_IDLE;
                end
            end
            default: st_nxt.rst = RD_IDLE;
        endcase
        // Configuration reload from fuses
        if (fuse_load_i) begin
            st_nxt.tracking = fuse_tracking_i;
            st_nxt.range = fuse_range_i;
        end
        // Reference and switching mode
        if (st_r.tracking) begin
            st_nxt.ref_mv = paired_buck_a_mv_i >> 1;
            st_nxt.sw_mode = PWM_MODE;
        end else begin
            st_nxt.ref_mv = dec_mv;
            st_nxt.sw_mode = st_r.mode;
        end
    end

    // Register the whole state
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st_r <= RESET_ST;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    logic [11:0] exp_low_mv;
    logic [11:0] exp_high_mv;
    assign exp_low_mv = LOW_BASE_MV + {6'h00, sel_code} * LOW_STEP_MV;
    assign exp_high_mv = HIGH_BASE_MV + {6'h00, sel_code} * HIGH_STEP_MV;

    sequence both_held_s;
        ce_i && st_r.wst == WR_IDLE && st_r.aw_held && st_r.w_held;
    endsequence

    sequence resp_held_s;
        s_axi_bvalid_o && !s_axi_bready_i;
    endsequence

    range_read_only_a: assert property (!(ce_i && fuse_load_i) |=> $stable(st_r.range))
        else $error("range bit changed without a fuse load");
    tracking_fuse_a: assert property (ce_i && fuse_load_i |=>
        st_r.tracking == $past(fuse_tracking_i))
        else $error("tracking bit did not follow the fuse load");
    track_reference_a: assert property (ce_i && st_r.tracking |=>
        ref_mv_o == ($past(paired_buck_a_mv_i) >> 1))
        else $error("tracking reference is not half the paired output");
    force_pwm_a: assert property (ce_i && st_r.tracking |=> sw_mode_o == PWM_MODE)
        else $error("switching mode not forced in tracking mode");
    low_range_a: assert property (ce_i && !st_r.tracking && !st_r.range |=>
        ref_mv_o == $past(exp_low_mv))
        else $error("low range decode wrong");
    high_range_a: assert property (ce_i && !st_r.tracking && st_r.range |=>
        ref_mv_o == $past(exp_high_mv))
        else $error("high range decode wrong");
    standby_select_a: assert property (op_state_i == OP_STANDBY |->
        sel_code == st_r.stby_code)
        else $error("standby state did not pick the standby code");
    mirror_read_a: assert property (ar_take && ar_idx == IDX_STANDBY |=>
        s_axi_rdata_o[RANGE_BIT] == $past(st_r.range))
        else $error("standby range mirror wrong on read");
    write_resp_a: assert property (both_held_s |=> s_axi_bvalid_o)
        else $error("write response did not follow the taken write");
    resp_hold_a: assert property (resp_held_s |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped before it was taken");
    write_commit_a: assert property (both_held_s ##0 st_r.wlane && !fuse_load_i
        && st_r.waddr == IDX_NORMAL |=> st_r.norm_code == $past(st_r.wdata[5:0])
        && $stable(st_r.range))
        else $error("normal set-point write not stored");

endmodule

// ### core/setpoint_decode.sv
// Set-point code to output millivolt decoder
`timescale 1ns/1ps
module setpoint_decode
    import buck_setpoint_pkg::*;
(
    input wire logic [5:0] code_i,
    input wire logic range_i,
    output logic [11:0] mv_o
);

    // ------------------------------------------------------------------
    // Linear coding in either range
    // ------------------------------------------------------------------
    logic [11:0] code_ext;
    assign code_ext = {6'h00, code_i};

    // Base plus step per code
    always_comb begin
        if (range_i) begin
            mv_o = HIGH_BASE_MV + code_ext * HIGH_STEP_MV;
        end else begin
            mv_o = LOW_BASE_MV + code_ext * LOW_STEP_MV;
        end
    end

endmodule
